/* File: rtl/pci_cfg_consts.svh */
// Offsets, field positions, masks and reset values of the per-socket
// identification and command/status configuration words.
// Assumes inclusion by bare name from the design files.
`ifndef PCI_CFG_CONSTS_SVH
`define PCI_CFG_CONSTS_SVH

// ****************************************************************
// Configuration space layout
// ****************************************************************
`define SOCKETS 2
`define CFG_ADDR_W 9
`define CFG_FUNC_BIT 8
`define CFG_OFF_ID 8'h00
`define CFG_OFF_CMDSTS 8'h04
`define CFG_OFF_CAP 8'h14
`define CFG_CAP_PTR_RST 8'h80

// ****************************************************************
// Command word (bits 15:0)
// ****************************************************************
`define CMD_IO_EN 0
`define CMD_MEM_EN 1
`define CMD_MASTER_EN 2
`define CMD_PAR_EN 6
`define CMD_SERR_EN 8
`define CMD_WR_MASK 16'h0147
`define CMD_RST 16'h0000

// ****************************************************************
// Status word (bits 31:16 of the dword)
// ****************************************************************
`define STS_MDPE 24
`define STS_SIG_TABORT 27
`define STS_RCV_TABORT 28
`define STS_RCV_MABORT 29
`define STS_SERR_GEN 30
`define STS_PAR_DET 31
`define STS_W1C_MASK 32'hF9000000
`define STS_FIXED 32'h02100000
`define STS_RST 1'b0

`endif

/* File: rtl/pci_cfg_pkg.sv */
// Types shared by the configuration header block.
// Assumes the constants header is compiled alongside.
package pci_cfg_pkg;

    // ************************************************************
    // Configuration request carried from the PCI target logic
    // ************************************************************
    typedef struct packed {
        logic we;
        logic [8:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // Per-socket accesses; all but the legacy ones need permission from the command bits
    typedef struct packed {
        logic io_reg;
        logic io_win;
        logic mem_reg;
        logic mem_win;
        logic legacy_io;
        logic legacy_mem;
        logic master_req;
    } sock_hit_t;

    // Per-socket bus events that feed the status bits
    typedef struct packed {
        logic addr_par_err;
        logic data_par_err;
        logic par_gen;
        logic master_active;
        logic tabort_signalled;
        logic tabort_received;
        logic mabort_received;
    } sock_evt_t;

    typedef enum logic [1:0] {
        CFG_IDLE = 2'b01,
        CFG_RESP = 2'b10
    } cfg_state_t;

endpackage : pci_cfg_pkg

/* File: rtl/sticky_status_bit.sv */
// One status bit set by hardware and cleared by writing one.
// Assumes set_i and clr_i are synchronous to sys_clk_i.
`timescale 1ns/100ps
`include "pci_cfg_consts.svh"

module sticky_status_bit (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    logic q;
    logic next_q;

    // ************************************************************
    // Next value: a set in the clearing cycle is kept
    // ************************************************************
    always_comb begin
        next_q = q;
        if (set_i) begin
            next_q = 1'b1;
        end else if (clr_i) begin
            next_q = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            q <= `STS_RST;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q;

endmodule : sticky_status_bit

/* File: rtl/pci_config_id_command_status.sv */
// Identification and command/status words of the two per-socket
// configuration headers, with the access gating and error
// reporting that those words control.
// Assumes the PCI target logic hands over decoded configuration
// requests, access hits and bus events synchronous to sys_clk_i.
`timescale 1ns/100ps
`include "pci_cfg_consts.svh"

module pci_config_id_command_status #(
    // Arbitrary identity values, replaced per product
    parameter logic [15:0] VENDOR_CODE = 16'hABCD,
    parameter logic [15:0] DEVICE_CODE = 16'h0001,
    parameter logic [7:0] CAP_PTR = `CFG_CAP_PTR_RST
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Configuration request port
    input wire logic cfg_req_i,
    input wire pci_cfg_pkg::cfg_req_t cfg_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    // Access permission per socket
    input wire pci_cfg_pkg::sock_hit_t [1:0] hit_i,
    output logic [1:0] io_claim_o,
    output logic [1:0] mem_claim_o,
    output logic [1:0] master_grant_o,
    // Bus events per socket
    input wire pci_cfg_pkg::sock_evt_t [1:0] evt_i,
    output logic [1:0] perr_report_o,
    output logic serr_n_o,
    // Command bits for the rest of the socket logic
    output logic [1:0] master_en_o,
    output logic [1:0] par_en_o
);
    import pci_cfg_pkg::*;

    // ************************************************************
    // Sized copies of the masks and fixed bits
    // ************************************************************
    // Each mask meets only words of its own width, bit for bit
    localparam logic [15:0] CMD_WR_MASK_W = `CMD_WR_MASK;
    localparam logic [31:0] STS_CLR_MASK_W = `STS_W1C_MASK;
    localparam logic [31:0] STS_FIXED_W = `STS_FIXED;

    // ************************************************************
    // Request handshake state
    // ************************************************************
    cfg_state_t state;
    cfg_state_t next_state;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic take;
    logic func;
    logic [7:0] off;

    // ************************************************************
    // Per-socket command and status storage
    // ************************************************************
    logic [15:0] cmd [`SOCKETS];
    logic [15:0] next_cmd [`SOCKETS];
    logic [31:0] sts_set [`SOCKETS];
    logic [31:0] sts_clr [`SOCKETS];
    logic [31:0] sts [`SOCKETS];
    logic [31:0] word_id;
    logic [31:0] word_cmdsts [`SOCKETS];

    // ************************************************************
    // Output registers for claims and error pins
    // ************************************************************
    logic [1:0] io_claim;
    logic [1:0] next_io_claim;
    logic [1:0] mem_claim;
    logic [1:0] next_mem_claim;
    logic [1:0] grant;
    logic [1:0] next_grant;
    logic [1:0] perr_rep;
    logic [1:0] next_perr_rep;
    logic serr_n;
    logic next_serr_n;
    logic [1:0] serr_fire;

    assign take = cfg_req_i && (state == CFG_IDLE);
    // Function select
    // The top address bit picks the socket's function
    assign func = cfg_i.addr[`CFG_FUNC_BIT];
    assign off = cfg_i.addr[7:0];

    // ************************************************************
    // Fixed identification word
    // ************************************************************
    // Device code in the upper half, vendor code in the lower
    assign word_id = {DEVICE_CODE, VENDOR_CODE};

    // ************************************************************
    // Request handshake: take in idle, answer one cycle later
    // ************************************************************
    // The answer cycle refuses requests, so a held request is taken
    // every other edge and each answer belongs to exactly one request
    always_comb begin
        next_state = state;
        next_rdata = rdata;
        unique case (state)
            CFG_IDLE: begin
                if (cfg_req_i) begin
                    next_state = CFG_RESP;
                    next_rdata = 32'h0000_0000;
                    if (!cfg_i.we) begin
                        unique case (off)
                            `CFG_OFF_ID: next_rdata = word_id;
                            `CFG_OFF_CMDSTS:
                                next_rdata = word_cmdsts[func];
                            `CFG_OFF_CAP:
                                next_rdata = {24'h00_0000, CAP_PTR};
                            // Unmapped offsets read zero
                            default: next_rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            CFG_RESP: begin
                next_state = CFG_IDLE;
            end
            default: begin
                next_state = CFG_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= CFG_IDLE;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            rdata <= next_rdata;
        end
    end

    assign cfg_ack_o = (state == CFG_RESP);
    assign cfg_rdata_o = rdata;

    // ************************************************************
    // Per-socket header
    // ************************************************************
    genvar s;
    genvar b;
    generate
        for (s = 0; s < `SOCKETS; s++) begin : g_sock
            logic wr_sel;
            logic par_en;
            logic serr_en;
            logic wr_cmd_lo;
            logic wr_cmd_hi;
            logic wr_sts_hi;

            assign wr_sel = take && cfg_i.we && (func == s) &&
                            (off == `CFG_OFF_CMDSTS);
            assign par_en = cmd[s][`CMD_PAR_EN];
            assign serr_en = cmd[s][`CMD_SERR_EN];

            // Byte enables pick the lanes; lane 2 holds no writable bit
            assign wr_cmd_lo = wr_sel && cfg_i.be[0];
            assign wr_cmd_hi = wr_sel && cfg_i.be[1];
            assign wr_sts_hi = wr_sel && cfg_i.be[3];

            // ****************************************************
            // Command bits
            // ****************************************************
            // Command: only enable bits take writes
            always_comb begin
                next_cmd[s] = cmd[s];
                if (wr_cmd_lo) begin
                    // Bits 3 to 5 and 7 not writable
                    next_cmd[s][7:0] =
                        cfg_i.wdata[7:0] & CMD_WR_MASK_W[7:0];
                end
                if (wr_cmd_hi) begin
                    next_cmd[s][15:8] =
                        cfg_i.wdata[15:8] & CMD_WR_MASK_W[15:8];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    cmd[s] <= `CMD_RST;
                end else begin
                    cmd[s] <= next_cmd[s];
                end
            end

            // Pin and status flag share one qualifier, so software never
            // finds the generated flag set without the pin having fired
            // Only a target address parity error qualifies
            assign serr_fire[s] = evt_i[s].addr_par_err &&
                                  serr_en && par_en;

            // ****************************************************
            // Status bits
            // ****************************************************
            // Status event sources
            always_comb begin
                sts_set[s] = 32'h0000_0000;
                sts_set[s][`STS_MDPE] = par_en &&
                    evt_i[s].master_active &&
                    (evt_i[s].data_par_err || evt_i[s].par_gen);
                sts_set[s][`STS_SIG_TABORT] =
                    evt_i[s].tabort_signalled;
                sts_set[s][`STS_RCV_TABORT] =
                    evt_i[s].tabort_received;
                sts_set[s][`STS_RCV_MABORT] =
                    evt_i[s].mabort_received;
                sts_set[s][`STS_SERR_GEN] = serr_fire[s];
                sts_set[s][`STS_PAR_DET] =
                    evt_i[s].addr_par_err || evt_i[s].data_par_err;
            end

            // Only ones clear; zeros leave bits alone
            assign sts_clr[s] = wr_sts_hi ?
                                ({cfg_i.wdata[31:24], 24'h00_0000} &
                                 STS_CLR_MASK_W) : 32'h0000_0000;

            for (b = 0; b < 32; b++) begin : g_bit
                // One flop per clearable bit; fixed bits cost nothing
                if (STS_CLR_MASK_W[b]) begin : g_w1c
                    sticky_status_bit u_bit (
                        .sys_clk_i(sys_clk_i),
                        .rst_i(rst_i),
                        .set_i(sts_set[s][b]),
                        .clr_i(sts_clr[s][b]),
                        .q_o(sts[s][b])
                    );
                end else begin : g_fixed
                    // DEVSEL timing is 01
                    // Fixed bits are wires, so no write can reach them
                    assign sts[s][b] = STS_FIXED_W[b];
                end
            end

            // Reserved command bits read zero through the mask on cmd, reserved status bits through the fixed bits
            assign word_cmdsts[s] = {sts[s][31:16], cmd[s]};

            assign master_en_o[s] = cmd[s][`CMD_MASTER_EN];
            assign par_en_o[s] = par_en;
        end
    endgenerate

    // ************************************************************
    // Access permission
    // ************************************************************
    // Claims are registered: one cycle of latency buys a short path
    // from the command flops to the target's decode
    always_comb begin
        for (int i = 0; i < `SOCKETS; i++) begin
            // I/O windows need the socket's own enable
            // Register I/O follows function 0 only
            next_io_claim[i] =
                (hit_i[i].io_reg && cmd[0][`CMD_IO_EN]) ||
                (hit_i[i].io_win && cmd[i][`CMD_IO_EN]) ||
                hit_i[i].legacy_io;
            next_mem_claim[i] =
                ((hit_i[i].mem_reg || hit_i[i].mem_win) &&
                 cmd[i][`CMD_MEM_EN]) ||
                hit_i[i].legacy_mem;
            next_grant[i] = hit_i[i].master_req &&
                            cmd[i][`CMD_MASTER_EN];
            // Data parity reporting gated by enable
            next_perr_rep[i] = evt_i[i].data_par_err &&
                               cmd[i][`CMD_PAR_EN];
        end
    end

    // Shared pin, driven low for one cycle after each cycle in which either socket has a qualifying error
    assign next_serr_n = ~|serr_fire;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_claim <= 2'h0;
            mem_claim <= 2'h0;
            grant <= 2'h0;
            perr_rep <= 2'h0;
            serr_n <= 1'b1;
        end else begin
            io_claim <= next_io_claim;
            mem_claim <= next_mem_claim;
            grant <= next_grant;
            perr_rep <= next_perr_rep;
            serr_n <= next_serr_n;
        end
    end

    assign io_claim_o = io_claim;
    assign mem_claim_o = mem_claim;
    // Grant is also dropped at once when mastering is disabled
    assign master_grant_o = grant & {cmd[1][`CMD_MASTER_EN],
                                     cmd[0][`CMD_MASTER_EN]};
    assign perr_report_o = perr_rep;
    assign serr_n_o = serr_n;

endmodule : pci_config_id_command_status

/* File: sim/pci_cfg_properties.sv */
// Port checker for the configuration header block.
// Assumes it is bound to every instance of the block by the bind below.
`timescale 1ns/100ps

module pci_cfg_properties #(
    parameter logic [15:0] VENDOR_CODE = 16'h0000,
    parameter logic [15:0] DEVICE_CODE = 16'h0000
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cfg_req_i,
    input wire pci_cfg_pkg::cfg_req_t cfg_i,
    input wire logic cfg_ack_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire pci_cfg_pkg::sock_hit_t [1:0] hit_i,
    input wire logic [1:0] io_claim_o,
    input wire logic [1:0] mem_claim_o,
    input wire logic [1:0] master_grant_o,
    input wire pci_cfg_pkg::sock_evt_t [1:0] evt_i,
    input wire logic [1:0] perr_report_o,
    input wire logic serr_n_o,
    input wire logic [1:0] master_en_o,
    input wire logic [1:0] par_en_o
);
    import pci_cfg_pkg::*;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // A read of one offset taken at this edge
    sequence s_take_rd(logic [7:0] off);
        cfg_req_i && !cfg_ack_o && !cfg_i.we && cfg_i.addr[7:0] == off;
    endsequence

    a_ack_follows: assert property (cfg_req_i && !cfg_ack_o |=> cfg_ack_o)
        else $error("request taken without an answer");
    a_ack_single: assert property (cfg_ack_o |=> !cfg_ack_o)
        else $error("answer longer than one cycle");
    a_ack_asked: assert property (cfg_ack_o |-> $past(cfg_req_i))
        else $error("answer without a request");
    a_id_value: assert property (
        s_take_rd(8'h00) |=> cfg_rdata_o == {DEVICE_CODE, VENDOR_CODE})
        else $error("identity word wrong");
    a_sts_fixed: assert property (
        s_take_rd(8'h04) |=> (cfg_rdata_o & 32'h06FFFEB8) == 32'h02100000)
        else $error("fixed command or status bits wrong");
    a_serr_cause: assert property (!serr_n_o |->
        $past(evt_i[0].addr_par_err && par_en_o[0]
        || evt_i[1].addr_par_err && par_en_o[1]))
        else $error("system error without address parity error");
    a_perr_gate: assert property (
        (perr_report_o & ~$past({evt_i[1].data_par_err & par_en_o[1],
        evt_i[0].data_par_err & par_en_o[0]})) == 2'h0)
        else $error("parity report without enabled data error");
    a_grant_gate: assert property (master_grant_o[0] |->
        master_en_o[0] && $past(hit_i[0].master_req))
        else $error("grant without enable or request");
    a_legacy_mem: assert property (
        !$past(rst_i) && $past(hit_i[1].legacy_mem) |-> mem_claim_o[1])
        else $error("legacy memory access not claimed");
endmodule : pci_cfg_properties

bind pci_config_id_command_status pci_cfg_properties #(
    .VENDOR_CODE(VENDOR_CODE),
    .DEVICE_CODE(DEVICE_CODE)
) u_props (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
    .cfg_i(cfg_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .hit_i(hit_i), .io_claim_o(io_claim_o), .mem_claim_o(mem_claim_o),
    .master_grant_o(master_grant_o), .evt_i(evt_i),
    .perr_report_o(perr_report_o), .serr_n_o(serr_n_o),
    .master_en_o(master_en_o), .par_en_o(par_en_o)
);

/* File: sim/pci_host_model.sv */
// Host side of the configuration port: one request at a time.
// Assumes the block answers each taken request one cycle later.
`timescale 1ns/100ps

module pci_host_model (
    input wire logic sys_clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    output logic cfg_req_o,
    output pci_cfg_pkg::cfg_req_t cfg_o
);
    import pci_cfg_pkg::*;

    initial begin
        cfg_req_o = 1'b0;
        cfg_o = '0;
    end

    // Entered just after a rising edge; holds all until ack is sampled
    task xfer(input logic we, input logic [8:0] a, input logic [3:0] be,
              input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        cfg_req_o = 1'b1;
        cfg_o = {we, a, be, wd};
        // Ack and data are taken at the rising edge that samples ack high
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 16);
        rd = (ack_i === 1'b1) ? rdata_i : 32'hXXXXXXXX;
        #1;
        cfg_req_o = 1'b0;
        // Released lines change, so a stale request cannot pass for valid
        cfg_o = ~cfg_o;
        // An idle edge keeps a following call from retoggling the request
        @(posedge sys_clk_i);
        #1;
    endtask : xfer
endmodule : pci_host_model

/* File: sim/tb_top.sv */
// Self-checking bench for the configuration header block.
// Assumes the host model drives the configuration port.
`timescale 1ns/100ps

module tb_top;
    import pci_cfg_pkg::*;

    localparam logic [15:0] VEN = 16'h5A5A; // Arbitrary identity value
    localparam logic [15:0] DEV = 16'hC3C3; // Arbitrary identity value
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_req, cfg_ack, serr_n;
    cfg_req_t cfg;
    logic [31:0] rdata;
    sock_hit_t [1:0] hit = '0;
    sock_evt_t [1:0] evt = '0;
    logic [1:0] io_claim, mem_claim, grant, perr, men, pen;
    int n_fail = 0;
    int tests_run = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    pci_host_model host (.sys_clk_i(sys_clk_i), .ack_i(cfg_ack),
        .rdata_i(rdata), .cfg_req_o(cfg_req), .cfg_o(cfg));

    pci_config_id_command_status #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV))
    uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_req_i(cfg_req),
        .cfg_i(cfg), .cfg_ack_o(cfg_ack), .cfg_rdata_o(rdata),
        .hit_i(hit), .io_claim_o(io_claim), .mem_claim_o(mem_claim),
        .master_grant_o(grant), .evt_i(evt), .perr_report_o(perr),
        .serr_n_o(serr_n), .master_en_o(men), .par_en_o(pen));

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task rd(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.xfer(1'b0, a, 4'hF, 32'h00000000, d);
        chk($sformatf("word %h", a), exp, d);
    endtask : rd

    task wr(input logic [8:0] a, input logic [3:0] be, input logic [31:0] w);
        logic [31:0] d;
        host.xfer(1'b1, a, be, w, d);
        // A write answers with zero data; a missing answer shows as X
        chk("write answer", 32'h00000000, d);
    endtask : wr

    // Claims are {io, mem, grant}, one edge after the hits
    task hits(input sock_hit_t [1:0] h, input logic [5:0] exp);
        hit = h;
        @(posedge sys_clk_i);
        #1;
        chk("claims", {26'h0, exp}, {26'h0, io_claim, mem_claim, grant});
        hit = '0;
        @(posedge sys_clk_i);
        #1;
    endtask : hits

    // Result is {perr report, serr_n} one edge after the events
    task pulse(input sock_evt_t [1:0] e, input logic [2:0] exp);
        evt = e;
        @(posedge sys_clk_i);
        #1;
        chk("perr serr", {29'h0, exp}, {29'h0, perr, serr_n});
        evt = '0;
        @(posedge sys_clk_i);
        #1;
    endtask : pulse

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_ident();
        rd(9'h000, {DEV, VEN});
        rd(9'h100, {DEV, VEN});
        rd(9'h014, 32'h00000080);
        rd(9'h108, 32'h00000000);
        wr(9'h000, 4'hF, 32'hFFFFFFFF);
        rd(9'h000, {DEV, VEN});
    endtask : t_ident

    task t_command();
        rd(9'h004, 32'h02100000);
        wr(9'h004, 4'h3, 32'hFFFFFFFF);
        rd(9'h004, 32'h02100147);
        rd(9'h104, 32'h02100000);
        chk("enables", 32'h5, {28'h0, men, pen});
    endtask : t_command

    task t_events();
        pulse(14'h0040, 3'b000);
        pulse(14'h2000, 3'b001);
        pulse(14'h1428, 3'b011);
        pulse(14'h0007, 3'b001);
        rd(9'h004, 32'hFB100147);
        rd(9'h104, 32'h82100000);
        wr(9'h004, 4'h8, 32'h00000000);
        rd(9'h004, 32'hFB100147);
        wr(9'h004, 4'h8, 32'h28000000);
        rd(9'h004, 32'hD3100147);
        wr(9'h004, 4'hF, 32'hFFFFFFFF);
        rd(9'h004, 32'h02100147);
        wr(9'h104, 4'h8, 32'h80000000);
        rd(9'h104, 32'h02100000);
    endtask : t_events

    task t_gating();
        hits(14'h2000, 6'b100000);
        hits(14'h1000, 6'b000000);
        hits(14'h0408, 6'b000100);
        hits(14'h0300, 6'b101000);
        hits(14'h0081, 6'b000001);
        wr(9'h004, 4'h3, 32'h00000000);
        hits(14'h2040, 6'b000000);
        hits(14'h0081, 6'b000000);
    endtask : t_gating

    task final_report();
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (4) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        t_ident();
        t_command();
        t_events();
        t_gating();
        final_report();
    end

    // Whole run is about a hundred cycles; allow about 5000
    initial begin
        #40000;
        n_fail++;
        final_report();
    end
endmodule : tb_top
